// ---- logic/bnr_pkg.sv ----
/*
 * Shared constants, types and reset values for the controller that drives
 * a bytewide nonvolatile RAM through its strobe, address and byte lane pins.
 * Assumes a single 40 MHz clock (25 ns period) and a synchronous reset.
 */
package bnr_pkg;

    // Widths of the external memory port and of the internal counters.
    localparam int ADDR_W = 15; // Byte address, one of 32,768 locations.
    localparam int DATA_W = 8; // Byte lane width.
    localparam int TMR_W = 7; // Width of the phase timer.
    localparam int CNT_W = 8; // Width of the strobe length counters.

    // Clock period and device timing in nanoseconds, and the lane synchroniser depth.
    localparam int CLK_NS = 25; // Clock period of ref_clk.
    localparam int ACC_NS = 70; // Access time, also least strobe low time.
    localparam int CA_MAX_NS = 2000; // Longest strobe low time.
    localparam int PRE_NS = 70; // Least precharge (strobe high) time.
    localparam int CYC_NS = 140; // Least full cycle time.
    localparam int DS_NS = 40; // Write data setup before the strobe rises.
    localparam int SYNC_STAGES = 2; // Flops on the returning byte lane.

    // Cycle counts: least times round up, longest times round down.
    localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CA_MAX_CYC = CA_MAX_NS / CLK_NS;
    localparam int PRE_CYC = (PRE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_CYC = (CYC_NS + CLK_NS - 1) / CLK_NS;
    localparam int DS_CYC = (DS_NS + CLK_NS - 1) / CLK_NS;

    // Strobe low lengths; a read also waits for the byte lane synchroniser.
    localparam int WR_LOW_CYC = (ACC_CYC >= DS_CYC) ? ACC_CYC : DS_CYC;
    localparam int RD_LOW_CYC = ACC_CYC + 1 + SYNC_STAGES;

    // Timer load values; the timer ends one cycle after it counts to zero.
    localparam logic [TMR_W-1:0] WR_LOW_LD = TMR_W'(WR_LOW_CYC - 1);
    localparam logic [TMR_W-1:0] RD_LOW_LD = TMR_W'(RD_LOW_CYC - 1);
    localparam logic [TMR_W-1:0] PRE_LD = TMR_W'(PRE_CYC - 1);

    // Saturation value of the strobe high length counter.
    localparam logic [CNT_W-1:0] CNT_SAT = 8'hFF;

    // Controller states.
    typedef enum logic [1:0] {
        BNR_IDLE = 2'b00,
        BNR_SETUP = 2'b01,
        BNR_ACTIVE = 2'b10,
        BNR_PRE = 2'b11
    } bnr_state_e;

    // One request from the user side.
    typedef struct packed {
        logic write; // High for a store, low for a read.
        logic [ADDR_W-1:0] addr; // Byte address.
        logic [DATA_W-1:0] wdata; // Byte to store.
    } bnr_req_s;

    // Strobe and address pins toward the memory, all active low strobes.
    typedef struct packed {
        logic cycle_strobe_n; // Starts each cycle on its falling edge.
        logic drive_enable_n; // Lets the memory drive the byte lane.
        logic store_strobe_n; // Marks the cycle as a store.
        logic [ADDR_W-1:0] byte_select_lines; // Byte address.
    } bnr_pins_s;

    // Pins while no cycle runs: every strobe high.
    localparam bnr_pins_s PINS_IDLE = '{
        cycle_strobe_n: 1'h1,
        drive_enable_n: 1'h1,
        store_strobe_n: 1'h1,
        byte_select_lines: 15'h0000
    };

    // Whole state of the controller.
    typedef struct packed {
        bnr_state_e st; // Sequencer state.
        bnr_pins_s pins; // Registered memory strobes and address.
        logic [DATA_W-1:0] lane_o; // Byte driven onto the lane.
        logic lane_oe_n; // Low while the controller drives the lane.
        logic is_write; // Kind of the cycle in progress.
        logic req_ready; // Controller can take a request.
        logic rsp_valid; // One-cycle completion pulse.
        logic [DATA_W-1:0] rsp_rdata; // Byte returned by the last read.
        logic [DATA_W-1:0] lane_s1; // First byte lane synchroniser flop.
        logic [DATA_W-1:0] lane_s2; // Second byte lane synchroniser flop.
        logic sup_s1; // First supply-good synchroniser flop.
        logic sup_s2; // Second supply-good synchroniser flop.
    } bnr_ctrl_s;

    // Reset value of the controller state.
    localparam bnr_ctrl_s CTRL_RST = '{
        st: BNR_IDLE,
        pins: PINS_IDLE,
        lane_o: 8'h00,
        lane_oe_n: 1'h1,
        is_write: 1'h0,
        req_ready: 1'h0,
        rsp_valid: 1'h0,
        rsp_rdata: 8'h00,
        lane_s1: 8'h00,
        lane_s2: 8'h00,
        sup_s1: 1'h0,
        sup_s2: 1'h0
    };

    // State of the phase timer.
    typedef struct packed {
        logic [TMR_W-1:0] count; // Cycles left in the phase.
        logic done; // Phase has run out.
    } bnr_tmr_s;

    // Reset value of the phase timer: idle and finished.
    localparam bnr_tmr_s TMR_RST = '{count: 7'h00, done: 1'h1};

endpackage : bnr_pkg

// ---- logic/bnr_timer.sv ----
/*
 * Phase timer of the memory controller: loads a count, runs it down once
 * per clock and flags when the phase is over.
 * Assumes its load comes from logic on the same clock.
 */
module bnr_timer (
    input wire logic ref_clk, // 40 MHz clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic load, // Start a new phase this cycle.
    input wire logic [bnr_pkg::TMR_W-1:0] value, // Cycles to wait, minus one.
    output logic done // High once the phase has run out.
);
    import bnr_pkg::*;

    bnr_tmr_s q; // Registered timer state.
    bnr_tmr_s d; // Next timer state.

    // A load wins; otherwise count down and stop at zero.
    always_comb begin
        d = q;
        if (load) begin
            d.count = value;
        end else if (q.count != '0) begin
            d.count = TMR_W'(q.count - 1'h1);
        end
        d.done = (d.count == '0);
    end

    // Registers the timer state.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= TMR_RST;
        end else begin
            q <= d;
        end
    end

    // The flag comes straight from its flop.
    assign done = q.done;

endmodule : bnr_timer

// ---- logic/bnr_ctrl.sv ----
/*
 * Controller that runs read and store cycles on a bytewide nonvolatile RAM
 * through its cycle, drive and store strobes, address and byte lane.
 * Assumes the lane pin is resolved outside from byte_lane_oe_n and that the
 * returning lane and the supply flag come from outside the clock domain.
 */
// What this block does
// - Every access needs its own cycle strobe fall.
// - Write ends at first rise; data set up.
// - Keep cycle strobe high for least precharge.
// - Never exceed longest cycle strobe low time.
// - Never tie cycle strobe low; pulse each access.
// - Withhold accesses while supply is out of tolerance.
// - Strobe low 70 to 2,000 ns, high 70 ns.
module bnr_ctrl (
    input wire logic ref_clk, // 40 MHz clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic supply_good, // Supply in tolerance, asynchronous level.
    input wire logic req_valid, // Request offered.
    input wire bnr_pkg::bnr_req_s req, // Request kind, address and byte.
    output logic req_ready, // Request taken when valid and ready.
    output logic rsp_valid, // One-cycle pulse when a cycle ends.
    output logic [bnr_pkg::DATA_W-1:0] rsp_rdata, // Byte from the last read.
    output bnr_pkg::bnr_pins_s pins, // Strobes and address to the memory.
    input wire logic [bnr_pkg::DATA_W-1:0] byte_lane_i, // Lane as seen.
    output logic [bnr_pkg::DATA_W-1:0] byte_lane_o, // Lane driven value.
    output logic byte_lane_oe_n // Low while the lane is driven.
);
    import bnr_pkg::*;

    bnr_ctrl_s q; // Registered controller state.
    bnr_ctrl_s d; // Next controller state.
    logic tmr_load; // Starts a strobe phase.
    logic [TMR_W-1:0] tmr_value; // Length of that phase, minus one.
    logic tmr_done; // Current phase has run out.

    // Times the low and high phases of the cycle strobe.
    bnr_timer u_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    // Sequences one memory cycle per request.
    always_comb begin
        d = q;
        tmr_load = 1'h0;
        tmr_value = '0;
        d.rsp_valid = 1'h0;
        // Returning lane and supply flag each pass two flops first.
        d.lane_s1 = byte_lane_i;
        d.lane_s2 = q.lane_s1;
        d.sup_s1 = supply_good;
        d.sup_s2 = q.sup_s1;
        case (q.st)
            BNR_IDLE: begin
                if (q.req_ready && req_valid) begin
                    // Address, store strobe and data go out a cycle early.
                    d.is_write = req.write;
                    d.pins.byte_select_lines = req.addr;
                    // A store holds the strobe low before the cycle falls.
                    d.pins.store_strobe_n = ~req.write;
                    // A read lets the memory drive; a store never does.
                    d.pins.drive_enable_n = req.write;
                    d.lane_o = req.wdata;
                    d.lane_oe_n = ~req.write;
                    d.req_ready = 1'h0;
                    d.st = BNR_SETUP;
                end else begin
                    // Accesses wait while the supply is out of tolerance.
                    d.req_ready = q.sup_s2;
                end
            end
            BNR_SETUP: begin
                // A fresh falling edge starts every single access.
                d.pins.cycle_strobe_n = 1'h0;
                tmr_load = 1'h1;
                // The read low phase also covers the lane synchroniser.
                tmr_value = q.is_write ? WR_LOW_LD : RD_LOW_LD;
                d.st = BNR_ACTIVE;
            end
            BNR_ACTIVE: begin
                if (tmr_done) begin
                    // All strobes rise together; precharge starts here.
                    d.pins = PINS_IDLE;
                    d.pins.byte_select_lines = q.pins.byte_select_lines;
                    d.lane_oe_n = 1'h1;
                    d.rsp_valid = 1'h1;
                    if (!q.is_write) begin
                        d.rsp_rdata = q.lane_s2;
                    end
                    tmr_load = 1'h1;
                    tmr_value = PRE_LD;
                    d.st = BNR_PRE;
                end
            end
            BNR_PRE: begin
                if (tmr_done) begin
                    // Next access may follow at once, even after a store.
                    d.req_ready = q.sup_s2;
                    d.st = BNR_IDLE;
                end
            end
            default: begin
                d = CTRL_RST;
            end
        endcase
    end

    // Registers the whole controller state.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // Every output comes straight from a flop of the state.
    assign req_ready = q.req_ready;
    assign rsp_valid = q.rsp_valid;
    assign rsp_rdata = q.rsp_rdata;
    assign pins = q.pins;
    assign byte_lane_o = q.lane_o;
    assign byte_lane_oe_n = q.lane_oe_n;

    logic [CNT_W-1:0] low_cnt_q; // Cycles the cycle strobe has been low.
    logic [CNT_W-1:0] high_cnt_q; // Cycles the cycle strobe has been high.

    // Measures strobe phases for the checks below.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            low_cnt_q <= '0;
            high_cnt_q <= CNT_SAT;
        end else if (!q.pins.cycle_strobe_n) begin
            low_cnt_q <= CNT_W'(low_cnt_q + 1'h1);
            high_cnt_q <= '0;
        end else begin
            low_cnt_q <= '0;
            if (high_cnt_q != CNT_SAT) begin
                high_cnt_q <= CNT_W'(high_cnt_q + 1'h1);
            end
        end
    end

    // Low phase reaches the access time before the strobe rises.
    a_low_min: assert property (
        @(posedge ref_clk) disable iff (srst)
        (q.pins.cycle_strobe_n && !$past(q.pins.cycle_strobe_n))
        |-> ($past(low_cnt_q) >= CNT_W'(ACC_CYC - 1)))
        else $error("Cycle strobe low shorter than access time.");

    // Low phase never exceeds the longest allowed time.
    a_low_max: assert property (
        @(posedge ref_clk) disable iff (srst)
        !q.pins.cycle_strobe_n |-> (low_cnt_q < CNT_W'(CA_MAX_CYC)))
        else $error("Cycle strobe low for too long.");

    // Precharge lasts its least time before the next fall.
    a_pre_min: assert property (
        @(posedge ref_clk) disable iff (srst)
        $fell(q.pins.cycle_strobe_n) |-> ($past(high_cnt_q) >= CNT_W'(PRE_CYC)))
        else $error("Precharge shorter than its least time.");

    // Whole cycle, low plus high, meets the least cycle time: the low
    // phase is at least three cycles, so four high cycles after each rise
    // bring the cycle to at least the six-cycle least cycle time.
    a_cycle_min: assert property (
        @(posedge ref_clk) disable iff (srst)
        (q.pins.cycle_strobe_n && !$past(q.pins.cycle_strobe_n))
        |-> q.pins.cycle_strobe_n [*4])
        else $error("Memory cycle shorter than least cycle time.");

    // Address stays put while the cycle strobe is low.
    a_addr_stable: assert property (
        @(posedge ref_clk) disable iff (srst)
        (!q.pins.cycle_strobe_n && !$past(q.pins.cycle_strobe_n))
        |-> $stable(q.pins.byte_select_lines))
        else $error("Address moved during a memory cycle.");

    // Store data is driven and steady while the store strobe is low.
    a_wdata_hold: assert property (
        @(posedge ref_clk) disable iff (srst)
        (!q.pins.store_strobe_n && !$past(q.pins.store_strobe_n))
        |-> (!q.lane_oe_n && $stable(q.lane_o)))
        else $error("Store data not held while storing.");

    // Controller and memory never drive the lane together.
    a_no_contend: assert property (
        @(posedge ref_clk) disable iff (srst)
        !q.lane_oe_n |-> q.pins.drive_enable_n)
        else $error("Lane driven from both ends.");

    // Store strobe is already low when the cycle strobe falls.
    a_store_first: assert property (
        @(posedge ref_clk) disable iff (srst)
        ($fell(q.pins.cycle_strobe_n) && q.is_write)
        |-> !$past(q.pins.store_strobe_n))
        else $error("Store strobe fell after the cycle strobe.");

    // Each completion pulse comes in the same cycle as its own strobe rise.
    a_one_access: assert property (
        @(posedge ref_clk) disable iff (srst)
        q.rsp_valid |-> (q.pins.cycle_strobe_n && !$past(q.pins.cycle_strobe_n)))
        else $error("Completion without its own memory cycle.");

    // No request is taken while the supply is reported bad.
    a_supply_hold: assert property (
        @(posedge ref_clk) disable iff (srst)
        q.req_ready |-> $past(q.sup_s2))
        else $error("Request accepted with supply out of tolerance.");

endmodule : bnr_ctrl

// ---- verif/bnr_mem_model.sv ----
/*
 * Behavioural model of the bytewide nonvolatile RAM on the far side of the
 * controller, with the resolved byte lane and a count of timing faults.
 * Assumes the controller's strobes, address and lane come from bnr_ctrl.
 */
module bnr_mem_model
    import bnr_pkg::*;
(
    input wire bnr_pkg::bnr_pins_s pins, // Strobes and address.
    input wire logic slow, // High makes the read access slower.
    input wire logic [7:0] ctl_lane, // Byte the controller drives.
    input wire logic ctl_oe_n, // Low while the controller drives.
    output logic [7:0] lane_seen, // Resolved level of the byte lane.
    output int viol // Count of strobe timing and contention faults.
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] mem [0:32767]; // Array, 32,768 bytes of 8 bits.
    logic [14:0] adr_l; // Address captured at the strobe fall.
    logic [7:0] rd_byte; // Byte ready for the lane.
    logic [7:0] lane_cur, lane_old; // Lane value now and before.
    logic armed, wr_cyc, wr_open, valid, mem_drv; // Cycle status.
    realtime t_fall, t_rise, t_cur, t_old; // Edge and change times.
    int cyc_id; // Numbers each cycle so stale timers are ignored.

    initial begin
        viol = 0;
        {armed, wr_cyc, wr_open, valid} = 4'h0;
        lane_seen = 8'h00;
        t_rise = -1000.0;
        cyc_id = 0;
    end

    // Captures the end value of a store, taking the pre-edge byte when the
    // lane changed in the very same step, and checks the data setup.
    task automatic close_write;
        logic [7:0] b;
        realtime t;
        if (t_cur == $realtime) begin
            b = lane_old;
            t = t_old;
        end else begin
            b = lane_cur;
            t = t_cur;
        end
        if (wr_open) begin
            if ($realtime - t < 40.0) viol++;
            mem[adr_l] = b;
            wr_open = 1'b0;
        end
    endtask : close_write

    // Falling cycle strobe captures the address and starts a cycle.
    always @(negedge pins.cycle_strobe_n) begin
        if ($realtime - t_rise < 70.0) viol++;
        adr_l = pins.byte_select_lines;
        wr_cyc = !pins.store_strobe_n;
        wr_open = wr_cyc;
        armed = 1'b1;
        valid = 1'b0;
        t_fall = $realtime;
        cyc_id++;
        // Read data turns valid after the access time, cycle goes on.
        fork
            begin
                automatic int me = cyc_id;
                #(slow ? 95.0 : 70.0);
                if (me == cyc_id && !wr_cyc) begin
                    rd_byte = mem[adr_l];
                    valid = 1'b1;
                end
            end
        join_none
    end

    // A late store strobe turns a read cycle into a store.
    always @(negedge pins.store_strobe_n) begin
        if (armed) begin
            wr_cyc = 1'b1;
            wr_open = 1'b1;
            valid = 1'b0;
        end
    end

    // The first rising strobe ends the write access.
    always @(posedge pins.store_strobe_n) begin
        if (armed) close_write();
    end

    // Rising cycle strobe ends the access and starts precharge.
    always @(posedge pins.cycle_strobe_n) begin
        if (armed) begin
            if ($realtime - t_fall < 70.0) viol++;
            if ($realtime - t_fall > 2000.0) viol++;
            close_write();
            armed = 1'b0;
            valid = 1'b0;
        end
        t_rise = $realtime;
    end

    // Drive enable gates only the output buffers.
    assign mem_drv = armed && valid && !wr_cyc
        && !pins.drive_enable_n && !pins.cycle_strobe_n;

    // Resolves the lane; a released lane shows the inverse of its last value.
    always @(ctl_lane or ctl_oe_n or mem_drv or rd_byte) begin
        if (ctl_oe_n === 1'b0 && mem_drv === 1'b1) viol++;
        if (ctl_oe_n === 1'b0) lane_seen = ctl_lane;
        else if (mem_drv === 1'b1) lane_seen = rd_byte;
        else lane_seen = ~lane_seen;
    end

    // Keeps the last two lane values for the write capture.
    always @(lane_seen) begin
        lane_old = lane_cur;
        t_old = t_cur;
        lane_cur = lane_seen;
        t_cur = $realtime;
    end

endmodule : bnr_mem_model

// ---- verif/tb.sv ----
/*
 * Self-checking testbench of bnr_ctrl against the memory model.
 * Assumes bnr_pkg and the fixed read and store latencies of the controller.
 */
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb;
    import bnr_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int RD_LAT = 8; // Take edge to sampled read response.
    localparam int WR_LAT = 5; // Take edge to sampled store response.

    typedef struct packed {
        logic rd; // Response of a read.
        logic [7:0] dat; // Byte the read must return.
        logic [31:0] at; // Cycle at which the response is sampled.
    } bnr_tb_exp_s;

    logic ref_clk, srst, supply_good, req_valid, slow; // Bench drives.
    bnr_req_s req; // Request fields.
    logic req_ready, rsp_valid, lane_oe_n; // Controller status.
    logic [7:0] rsp_rdata, lane_i, lane_o; // Read byte and lane.
    bnr_pins_s pins; // Memory strobes and address.
    int viol, n_fail, checks_done, tmo; // Counters.
    logic [31:0] cyc; // Cycle count, stepped on the falling edge.
    bnr_tb_exp_s exp_q[$]; // Expected responses, oldest first.
    bnr_tb_exp_s e; // Note being compared.
    logic [7:0] shadow [0:32767]; // Bytes the bench has stored.
    logic [14:0] ad [0:7]; // Random addresses for mixed traffic.
    logic [14:0] bnd [0:3] = '{15'h0000, 15'h7FFF, 15'h4000, 15'h0001};

    bnr_ctrl bnr_ctrl_inst (.ref_clk(ref_clk), .srst(srst),
        .supply_good(supply_good), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .pins(pins), .byte_lane_i(lane_i), .byte_lane_o(lane_o),
        .byte_lane_oe_n(lane_oe_n));

    bnr_mem_model bnr_mem_model_inst (.pins(pins), .slow(slow),
        .ctl_lane(lane_o), .ctl_oe_n(lane_oe_n), .lane_seen(lane_i),
        .viol(viol));

    // Clock at 40 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Cycle count and hang guard.
    always @(negedge ref_clk) cyc <= cyc + 1;
    always @(posedge ref_clk) begin
        tmo++;
        if (tmo == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("counts: %0d compared, %0d wrong", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Offers one request until taken or 100 cycles pass and notes the expected response.
    task automatic do_req(input logic wr, input logic [14:0] a,
                          input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{write: wr, addr: a, wdata: d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        exp_q.push_back('{rd: !wr, dat: wr ? d : shadow[a],
                          at: cyc + (wr ? WR_LAT : RD_LAT)});
        if (wr) shadow[a] = d;
        req_valid <= 1'b0;
    endtask : do_req

    // Compares each response with the oldest note.
    always @(posedge ref_clk) begin
        if (srst === 1'b0 && rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) `CHK(rsp_valid, 1'b0)
            else begin
                e = exp_q.pop_front();
                `CHK(cyc, e.at)
                if (e.rd) `CHK(rsp_rdata, e.dat)
            end
        end
    end

    // Main sequence.
    initial begin
        {srst, supply_good, req_valid, slow} = 4'b1000;
        req = '0;
        {cyc, n_fail, checks_done, tmo} = '0;
        void'($urandom(63));
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        // No request is taken while the supply is out of tolerance.
        repeat (20) begin
            @(posedge ref_clk);
            `CHK(req_ready, 1'b0)
        end
        supply_good <= 1'b1;
        $display("test supply_hold done");
        // Boundary addresses with bytes A5 and 5A, each read right after its store.
        for (int i = 0; i < 4; i++) begin
            do_req(1'b1, bnd[i], 8'hA5 ^ {8{i[0]}});
            do_req(1'b0, bnd[i], 8'h00);
        end
        for (int i = 0; i < 4; i++) do_req(1'b0, bnd[i], 8'h00);
        $display("test boundaries done");
        // Random mixed traffic with prompt and slow memory answers.
        for (int i = 0; i < 8; i++) begin
            ad[i] = 15'($urandom);
            do_req(1'b1, ad[i], 8'($urandom));
        end
        repeat (40) begin
            slow <= 1'($urandom);
            do_req(1'($urandom), ad[$urandom % 8], 8'($urandom));
        end
        $display("test random_mix done");
        // A reset right after a take aborts the cycle before it starts.
        do_req(1'b0, ad[0], 8'h00);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        exp_q.delete();
        `CHK(pins, PINS_IDLE)
        `CHK({req_ready, rsp_valid, rsp_rdata, lane_oe_n}, 11'h001)
        srst <= 1'b0;
        do_req(1'b0, ad[0], 8'h00);
        // Supply drop withholds requests until it returns.
        repeat (12) @(posedge ref_clk);
        supply_good <= 1'b0;
        repeat (6) @(posedge ref_clk);
        `CHK(req_ready, 1'b0)
        supply_good <= 1'b1;
        do_req(1'b0, ad[1], 8'h00);
        repeat (12) @(posedge ref_clk);
        $display("test reset_abort done");
        `CHK(exp_q.size(), 0)
        `CHK(viol, 0)
        tally_and_finish();
    end

endmodule : tb
